// File: eic_pkg.sv
// package for the eight-channel input image block with diagnostics
// assumes an apb slave with 32-bit data and a single 50 mhz clock
package eic_pkg;

  // ****************************************************************
  // image geometry
  // ****************************************************************
  localparam int unsigned CHAN_NUM   = 8;   // channels per module
  localparam int unsigned IMAGE_BYTES = 2;  // bytes per image direction

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [11:0] OFS_IN_IMAGE  = 12'h000;  // input image: state byte, fault byte
  localparam logic [11:0] OFS_OUT_IMAGE = 12'h004;  // output image: reserved byte, disable byte
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h008;  // sticky fault events, read only
  localparam logic [11:0] OFS_IRQ_EN    = 12'h00c;  // interrupt enable
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h010;  // write one to clear, reads zero

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned FIRST_LSB  = 0;   // first image byte
  localparam int unsigned SECOND_LSB = 8;   // second image byte
  localparam logic [7:0]  DISABLE_RST = 8'h00;  // all channels on after reset
  localparam logic [7:0]  RESERVED_VAL = 8'h00; // reserved byte always zero
  localparam logic [7:0]  IRQ_EN_RST  = 8'h00;
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

  // apb slave states
  typedef enum logic [0:0] {EIC_IDLE, EIC_ACCESS} eic_state_t;

endpackage

// File: eic_fault_sticky.sv
// sticky event bits for channel faults, one per channel
// assumes fault inputs synchronous to sys_clk
`timescale 1ns/10ps
module eic_fault_sticky (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] fault_in,    // live fault levels
  input  wire logic [7:0] clr_mask,    // one-cycle clear pulses
  output logic      [7:0] sticky_q     // latched fault events
);

  // ****************************************************************
  // fault edge detect and sticky latch
  // ****************************************************************
  logic [7:0] fault_prev_q;   // previous fault level
  logic [7:0] rise;           // new fault this cycle

  assign rise = fault_in & ~fault_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < eic_pkg::CHAN_NUM; gi++) begin : g_bit
      // set wins over clear so a new (rising) fault in the clear cycle is kept
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          sticky_q[gi]     <= 1'b0;
          fault_prev_q[gi] <= 1'b0;
        end else begin
          fault_prev_q[gi] <= fault_in[gi];
          if (rise[gi]) begin
            sticky_q[gi] <= 1'b1;
          end else if (clr_mask[gi]) begin
            sticky_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

// File: eic_image_regs.sv
// process image register bank for an eight-channel input module
// assumes an apb master on sys_clk and field inputs already synchronous
// assumes the master keeps address and write data steady through the access phase
// assumes one apb slot per word; bits above the second byte read as zero
`timescale 1ns/10ps

// Operation
// - two-byte input and output images
// - first input byte holds channel states
// - second input byte holds fault flags
// - second output byte: one disables channel
module eic_image_regs (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  input_channel_state,  // live channel levels
  input  wire logic [7:0]  channel_fault,        // wire break or short, per channel
  output logic      [7:0]  channel_switch_off,   // one switches a channel off
  output logic             irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  eic_pkg::eic_state_t state_q;          // apb phase
  logic [7:0]  state_byte_q;             // sampled channel states
  logic [7:0]  fault_byte_q;             // sampled fault flags
  logic [7:0]  disable_q;                // channel disable byte
  logic [7:0]  irq_en_q;                 // interrupt enables
  logic [7:0]  sticky;                   // sticky fault events
  logic [7:0]  clr_pulse;                // clear pulses to sticky bits

  // ****************************************************************
  // decode
  // ****************************************************************
  wire setup      = psel && !penable;
  wire acc        = psel && penable && (state_q == eic_pkg::EIC_ACCESS);
  wire hit_in     = (paddr == eic_pkg::OFS_IN_IMAGE);
  wire hit_out    = (paddr == eic_pkg::OFS_OUT_IMAGE);
  wire hit_stat   = (paddr == eic_pkg::OFS_IRQ_STAT);
  wire hit_en     = (paddr == eic_pkg::OFS_IRQ_EN);
  wire hit_clr    = (paddr == eic_pkg::OFS_IRQ_CLR);
  wire mapped     = hit_in | hit_out | hit_stat | hit_en | hit_clr;
  // writes to read-only words and unmapped addresses answer with an error
  wire bad        = !mapped || (pwrite && (hit_in || hit_stat));
  // a write lands on the access edge, where the master sees pready high;
  // committing at setup would act before the transfer is complete
  wire wr_ok      = acc && pwrite && !bad;
  wire wr_lane1   = pstrb[1];
  wire wr_lane0   = pstrb[0];

  // two-byte images in one word
  // read data mux, byte lanes as in the image
  wire [31:0] rd_mux =
    hit_in   ? {16'h0000, fault_byte_q, state_byte_q} :
    hit_out  ? {16'h0000, disable_q, eic_pkg::RESERVED_VAL} :
    hit_stat ? {24'h000000, sticky} :
    hit_en   ? {24'h000000, irq_en_q} : eic_pkg::RDATA_ZERO;

  assign clr_pulse = (wr_ok && hit_clr && wr_lane0) ? pwdata[7:0] : 8'h00;

  // ****************************************************************
  // next values of the software-visible registers
  // ****************************************************************
  // lane one carries the disable byte, lane zero the enable byte
  wire       dis_wr    = wr_ok && hit_out && wr_lane1;
  wire       en_wr     = wr_ok && hit_en && wr_lane0;
  wire [7:0] disable_d = dis_wr ? pwdata[15:8] : disable_q;
  wire [7:0] irq_en_d  = en_wr ? pwdata[7:0] : irq_en_q;
  // level interrupt: any enabled sticky event
  wire       irq_d     = |(sticky & irq_en_q);

  // ****************************************************************
  // apb handshake: one wait-free access phase
  // ****************************************************************
  // setup is taken, answer one cycle later with pready high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= eic_pkg::EIC_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= eic_pkg::RDATA_ZERO;
    end else begin
      unique case (state_q)
        eic_pkg::EIC_IDLE: begin
          pready  <= setup;
          pslverr <= setup && bad;
          prdata  <= (setup && !pwrite && mapped) ? rd_mux : eic_pkg::RDATA_ZERO;
          if (setup) begin
            state_q <= eic_pkg::EIC_ACCESS;
          end
        end
        eic_pkg::EIC_ACCESS: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          // read data stands for the answer cycle only
          prdata  <= eic_pkg::RDATA_ZERO;
          state_q <= eic_pkg::EIC_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // input image sampling
  // ****************************************************************
  // channel states to first byte
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_byte_q <= 8'h00;
      fault_byte_q <= 8'h00;
    end else begin
      state_byte_q <= input_channel_state;
      fault_byte_q <= channel_fault;
    end
  end

  // ****************************************************************
  // output image and interrupt enable
  // ****************************************************************
  // disables reset to zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      disable_q <= eic_pkg::DISABLE_RST;
      irq_en_q  <= eic_pkg::IRQ_EN_RST;
    end else begin
      disable_q <= disable_d;
      irq_en_q  <= irq_en_d;
    end
  end

  // ****************************************************************
  // outputs straight from flip-flops
  // ****************************************************************
  // drive channel disables
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      channel_switch_off <= eic_pkg::DISABLE_RST;
      irq                <= 1'b0;
    end else begin
      channel_switch_off <= disable_q;
      irq                <= irq_d;
    end
  end

  // sticky fault events, set beats clear
  eic_fault_sticky u_sticky (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .fault_in (channel_fault),
    .clr_mask (clr_pulse),
    .sticky_q (sticky)
  );

  // ****************************************************************
  // assertions
  // ****************************************************************
  // write setup aimed at the disable byte
  sequence s_out_write;
    psel && !penable && pwrite && (paddr == eic_pkg::OFS_OUT_IMAGE) && pstrb[1];
  endsequence

  // write setup aimed at the interrupt enable byte
  sequence s_en_write;
    psel && !penable && pwrite && (paddr == eic_pkg::OFS_IRQ_EN) && pstrb[0];
  endsequence

  // read setup of the input image word
  sequence s_in_read;
    setup && !pwrite && hit_in;
  endsequence

  // read setup of the output image word
  sequence s_out_read;
    setup && !pwrite && hit_out;
  endsequence

  // the answer: pready for exactly one cycle
  sequence s_one_answer;
    pready ##1 !pready;
  endsequence

  // first input byte mirrors the channel levels one cycle late
  AST_STATE_BYTE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ##1 1'b1 |-> state_byte_q == $past(input_channel_state))
    else $error("state byte not tracking inputs");

  // second input byte mirrors the fault levels one cycle late
  AST_FAULT_BYTE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ##1 1'b1 |-> fault_byte_q == $past(channel_fault))
    else $error("fault byte not tracking faults");

  // a write lands on the access edge and reaches the pins one cycle later
  AST_DISABLE_WR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_out_write |-> ##3 channel_switch_off == $past(pwdata[15:8], 3))
    else $error("disable byte write not seen at outputs");

  // without a write the disable byte holds
  AST_DISABLE_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(psel && pwrite) |=> $stable(disable_q))
    else $error("disable byte changed without write");

  // the reserved byte always reads zero
  AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == eic_pkg::EIC_ACCESS) && hit_out && !pwrite |-> prdata[7:0] == 8'h00)
    else $error("reserved byte read nonzero");

  // every channel is switched on after reset
  AST_RESET_ON: assert property (@(posedge sys_clk)
    $rose(arst_n) |-> channel_switch_off == 8'h00)
    else $error("channels not on after reset");

  // the image read returns the bytes seen at the setup edge
  AST_IMAGE_READ: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_in_read |=> pready && prdata[31:16] == 16'h0000
      && prdata[15:0] == {$past(fault_byte_q), $past(state_byte_q)})
    else $error("input image read wrong");

  // no wait states: one answer cycle per setup
  AST_READY_ONE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    setup |=> s_one_answer)
    else $error("apb answer not one cycle");

  // a rising fault latches its event bit
  AST_STICKY_SET: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (channel_fault[0] && !$past(channel_fault[0])) |=> sticky[0])
    else $error("fault event not latched");

  // ****************************************************************
  // assertions: refusals, clears and interrupt level
  // ****************************************************************
  // unmapped words answer with an error and zero data
  AST_UNMAPPED_ERR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    setup && !mapped |=> pready && pslverr && prdata == eic_pkg::RDATA_ZERO)
    else $error("unmapped access not refused");

  // the input image word cannot be written
  AST_IN_WRITE_ERR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    setup && pwrite && hit_in |=> pready && pslverr)
    else $error("input image write not refused");

  // the sticky event word cannot be written
  AST_STAT_WRITE_ERR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    setup && pwrite && hit_stat |=> pready && pslverr)
    else $error("event word write not refused");

  // outside the answer cycle the bus outputs rest at zero
  AST_IDLE_QUIET: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !pready |-> !pslverr && prdata == eic_pkg::RDATA_ZERO)
    else $error("bus outputs not quiet between answers");

  // a read of the output image returns the disable byte seen at setup
  AST_OUT_READ: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_out_read |=> pready && !pslverr && prdata[15:8] == $past(disable_q))
    else $error("disable byte read wrong");

  // an enable write lands on the access edge
  AST_EN_WRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_en_write |-> ##2 irq_en_q == $past(pwdata[7:0], 2))
    else $error("enable byte write lost");

  // a clear with no fault present drops the event bit
  AST_CLEAR_WORKS: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clr_pulse[0] && !channel_fault[0] |=> !sticky[0])
    else $error("event bit not cleared");

  // a new fault in the clear cycle keeps the event bit set
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clr_pulse[0] && channel_fault[0] && !$past(channel_fault[0]) |=> sticky[0])
    else $error("clear beat a new fault");

  // an enabled event raises the interrupt one cycle later
  AST_IRQ_RISE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    irq_d |=> irq)
    else $error("interrupt missing");

  // with no enabled event the interrupt falls one cycle later
  AST_IRQ_FALL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !irq_d |=> !irq)
    else $error("interrupt stuck high");

  // the disable outputs follow the disable byte one cycle late
  AST_SWITCH_TRACK: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ##1 1'b1 |-> channel_switch_off == $past(disable_q))
    else $error("disable outputs not following the byte");

  // reset leaves the answer, the interrupt and the disable byte low
  AST_RESET_QUIET: assert property (@(posedge sys_clk)
    $rose(arst_n) |-> !irq && !pready && !pslverr && disable_q == eic_pkg::DISABLE_RST)
    else $error("outputs busy after reset");

  // the access phase always returns to idle
  AST_ACCESS_ONE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == eic_pkg::EIC_ACCESS |=> state_q == eic_pkg::EIC_IDLE)
    else $error("access phase stretched");

  // every answer stems from a setup one cycle before
  AST_READY_CAUSE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pready |-> $past(setup))
    else $error("answer without a setup");

endmodule

// File: eic_field_model.sv
// field side model: eight sensor channels with level and fault signals
// assumes requests from the bench arrive on sys_clk; outputs move only on a rising edge
`timescale 1ns/10ps
module eic_field_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] state_req,  // wanted channel levels
  input  wire logic [7:0] fault_req,  // wanted wire break or short flags
  output logic      [7:0] chan_state, // levels seen by the module
  output logic      [7:0] chan_fault  // faults seen by the module
);
  // ****************************************************************
  // field update
  // ****************************************************************
  // synchronous so the design never sees a glitch mid-cycle
  always @(posedge sys_clk) begin
    chan_state <= state_req;
    chan_fault <= fault_req;
  end
endmodule

// File: eic_image_regs_tb.sv
// bench for the image register bank: apb master, field model, queue scoreboard
// assumes an apb slave; the master waits for pready however long it takes
`timescale 1ns/10ps
module eic_image_regs_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'hf;
  logic [31:0] prdata;
  logic        pready, pslverr, irq;
  logic [7:0]  st_req  = 8'h00;   // field level request
  logic [7:0]  flt_req = 8'h00;   // field fault request
  logic [7:0]  chan_st, chan_flt, sw_off;
  logic [33:0] notes[$];          // {check data, slverr, data}
  logic [33:0] cur;
  logic [7:0]  r;
  int          miscompares = 0;
  int          compares    = 0;

  always #10 sys_clk = ~sys_clk;

  eic_field_model eic_field_model_i (.sys_clk(sys_clk), .state_req(st_req), .fault_req(flt_req),
    .chan_state(chan_st), .chan_fault(chan_flt));
  eic_image_regs eic_image_regs_i (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_channel_state(chan_st), .channel_fault(chan_flt),
    .channel_switch_off(sw_off), .irq(irq));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one apb transfer; the expected answer is queued for the monitor
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] n);
    @(posedge sys_clk);
    notes.push_back(n);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // hold the request until the rising edge at which pready is high
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic err, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, {1'b1, err, exp});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    xfer(1'b1, a, d, {1'b0, err, 32'h0000_0000});
  endtask

  // monitor: oldest note against each answer, mid-cycle when settled
  always @(negedge sys_clk) begin
    if (pready === 1'b1) begin
      cur = (notes.size() > 0) ? notes.pop_front() : 34'h3_ffff_ffff;
      check({31'h0, pslverr}, {31'h0, cur[32]});
      if (cur[33]) check(prdata, cur[31:0]);
    end
  end

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #(20 * 5000);
    miscompares++;
    finish_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h56fe));
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    check({24'h0, sw_off}, 32'h0000_0000);
    rd(eic_pkg::OFS_OUT_IMAGE, 1'b0, 32'h0000_0000);
    // random images, back to back with readback of the disable byte
    for (int i = 0; i < 6; i++) begin
      st_req  <= 8'($urandom);
      flt_req <= 8'($urandom);
      r = 8'($urandom);
      repeat (3) @(posedge sys_clk);
      rd(eic_pkg::OFS_IN_IMAGE, 1'b0, {16'h0, flt_req, st_req});
      wr(eic_pkg::OFS_OUT_IMAGE, {16'h0, r, 8'h00}, 1'b0);
      repeat (2) @(negedge sys_clk);
      check({24'h0, sw_off}, {24'h0, r});
      rd(eic_pkg::OFS_OUT_IMAGE, 1'b0, {16'h0, r, 8'h00});
    end
    // interrupt: masked event, enabled event, clear
    flt_req <= 8'h00;
    wr(eic_pkg::OFS_IRQ_CLR, 32'h0000_00ff, 1'b0);
    wr(eic_pkg::OFS_IRQ_EN, 32'h0000_0001, 1'b0);
    rd(eic_pkg::OFS_IRQ_EN, 1'b0, 32'h0000_0001);
    flt_req <= 8'h02;
    repeat (4) @(negedge sys_clk);
    check({31'h0, irq}, 32'h0000_0000);
    rd(eic_pkg::OFS_IRQ_STAT, 1'b0, 32'h0000_0002);
    flt_req <= 8'h03;
    repeat (4) @(negedge sys_clk);
    check({31'h0, irq}, 32'h0000_0001);
    wr(eic_pkg::OFS_IRQ_CLR, 32'h0000_0001, 1'b0);
    repeat (3) @(negedge sys_clk);
    check({31'h0, irq}, 32'h0000_0000);
    rd(eic_pkg::OFS_IRQ_STAT, 1'b0, 32'h0000_0002);
    rd(eic_pkg::OFS_IRQ_CLR, 1'b0, 32'h0000_0000);
    // refused accesses: unmapped and read-only words
    rd(12'h020, 1'b1, 32'h0000_0000);
    wr(eic_pkg::OFS_IN_IMAGE, 32'h0000_ffff, 1'b1);
    wr(eic_pkg::OFS_IRQ_STAT, 32'h0000_00ff, 1'b1);
    rd(eic_pkg::OFS_IRQ_STAT, 1'b0, 32'h0000_0002);
    repeat (3) @(posedge sys_clk);
    finish_test();
  end
endmodule
